// *** core/lnk_cfg.svh ***
// constants of the link transaction bridge
`ifndef LNK_CFG_SVH
`define LNK_CFG_SVH
`define LNK_NB 6
`define LNK_NP 3
`define LNK_OP_RD 8'h01
`define LNK_OP_WR 8'h02
`define LNK_OP_PRB 8'h03
`define LNK_OP_FLS 8'h04
`define LNK_OP_RSP 8'h80
`define LNK_LINE_SH 7
`define LNK_FLOW_CONTROL_DIGIT_SH 4
`define LNK_BDF_MAX 4'he
`define LNK_ACC_BASE 16'h0040
`define LNK_REG_BASE 16'h0060
`define LNK_REG_RIGHT 20
`define LNK_REG_OWN 21
`define LNK_REG_TVT 12
`define LNK_SN_LD 2'h1
`define LNK_SN_ST 2'h2
`define LNK_SN_INV 2'h3
`define LNK_PG_SH 12
`endif

// *** core/lnk_pkg.sv ***
// types shared by the link transaction bridge
package lnk_pkg;
  typedef struct packed {logic [127:0] d; logic [3:0] p;} lnk_flow_control_digit_t;
  typedef struct packed {logic v; logic crc_ok; lnk_flow_control_digit_t f;} lnk_rx_t;
  typedef struct packed {logic v; lnk_flow_control_digit_t f;} lnk_tx_t;
  typedef struct packed {logic [7:0] op; logic [7:0] sz; logic [47:0] tag; logic [63:0] addr;} lnk_cmd_t;
  typedef struct packed {logic v; logic [7:0] op; logic [63:0] addr; logic [1:0] line;} lnk_fcmd_t;
  typedef struct packed {logic v; logic [1:0] line; logic [1:0] oct; logic [255:0] d;} lnk_fdat_t;
  typedef struct packed {logic v; logic [1:0] op; logic [63:0] addr; logic [63:0] d;} lnk_snp_t;
  typedef struct packed {logic v; logic we; logic [31:0] addr; logic [63:0] d;} lnk_pri_t;
  typedef struct packed {logic v; logic [3:0] bdf; logic [7:0] pasid; logic [63:0] addr;} lnk_xreq_t;
  typedef struct packed {logic v; logic ok; logic [7:0] ctx; logic [63:0] addr;} lnk_xrsp_t;
  typedef struct packed {logic v; logic [63:0] addr; logic [255:0] d;} lnk_line_t;
  typedef struct packed {logic v; logic [19:0] tag; logic [19:0] base;} lnk_tvt_t;
  typedef enum logic [1:0] {C_HDR = 2'b01, C_DAT = 2'b10} lnk_cst_t;
  typedef enum logic [4:0] {
    E_IDLE = 5'b00001, E_ISSUE = 5'b00010, E_WDATA = 5'b00100, E_WAIT = 5'b01000, E_RESP = 5'b10000
  } lnk_est_t;

  // one parity bit per 32-bit slice, even unless odd is set
  function automatic logic [3:0] lnk_par(logic [127:0] d, logic odd);
    logic [3:0] p;
    for (int i = 0; i < 4; i++) begin
      p[i] = (^d[32*i +: 32]) ^ odd;
    end
    return p;
  endfunction
endpackage

// *** core/lnk_flow_control_digit_check.sv ***
// per-brick flow_control_digit validation, command buffer and write data buffer
`timescale 1ns/1ps
`default_nettype none
`include "lnk_cfg.svh"
module lnk_flow_control_digit_check (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic odd,
  input wire lnk_pkg::lnk_rx_t rx,
  output lnk_pkg::lnk_cmd_t cmd,
  output logic cmd_v,
  input wire logic cmd_take,
  output logic [255:0] beat,
  output logic beat_v,
  output logic beat_last,
  input wire logic beat_take,
  output logic credit,
  output logic err
);
  typedef struct packed {
    lnk_pkg::lnk_cst_t st;
    logic cv;
    logic taken;
    lnk_pkg::lnk_cmd_t cmd;
    logic [15:0][127:0] dbuf;
    logic [4:0] wcnt;
    logic [4:0] need;
    logic [3:0] rptr;
    logic credit;
    logic err;
  } lnk_chk_s_t;
  lnk_chk_s_t s_reg, s_next;
  logic good;
  logic wr;
  lnk_pkg::lnk_cmd_t hdr;

  assign hdr = lnk_pkg::lnk_cmd_t'(rx.f.d);
  assign good = rx.crc_ok && (rx.f.p == lnk_pkg::lnk_par(rx.f.d, odd));
  assign wr = s_reg.cmd.op == `LNK_OP_WR;
  assign cmd = s_reg.cmd;
  assign cmd_v = s_reg.cv;
  assign beat = {s_reg.dbuf[{s_reg.rptr[2:0], 1'b1}], s_reg.dbuf[{s_reg.rptr[2:0], 1'b0}]};
  assign beat_v = s_reg.taken && wr && ({s_reg.rptr, 1'b0} < s_reg.wcnt);
  assign beat_last = {s_reg.rptr + 4'h1, 1'b0} >= s_reg.wcnt;
  assign credit = s_reg.credit;
  assign err = s_reg.err;

  always_comb begin
    s_next = s_reg;
    s_next.credit = 1'b0;
    s_next.err = 1'b0;
    if (cmd_take) begin
      s_next.taken = 1'b1;
    end
    if (beat_take) begin
      s_next.rptr = s_reg.rptr + 4'h1;
    end
    // buffer freed: return one credit to the link
    if (s_reg.taken && (!wr || (beat_take && beat_last))) begin
      s_next.cv = 1'b0;
      s_next.taken = 1'b0;
      s_next.wcnt = 5'h0;
      s_next.rptr = 4'h0;
      s_next.credit = 1'b1;
    end
    unique case (s_reg.st)
      lnk_pkg::C_HDR: begin
        if (rx.v) begin
          // only flits passing parity, crc and syntax enter the buffer
          if (good && !s_reg.cv && hdr.op >= `LNK_OP_RD && hdr.op <= `LNK_OP_FLS) begin
            s_next.cmd = hdr;
            if (hdr.op == `LNK_OP_WR) begin
              s_next.need = {1'b0, hdr.sz[7:`LNK_FLOW_CONTROL_DIGIT_SH]} + 5'h1;
              s_next.st = lnk_pkg::C_DAT;
            end else begin
              s_next.cv = 1'b1;
            end
          end else begin
            s_next.err = 1'b1;
          end
        end
      end
      lnk_pkg::C_DAT: begin
        if (rx.v) begin
          if (good) begin
            s_next.dbuf[s_reg.wcnt[3:0]] = rx.f.d;
            s_next.wcnt = s_reg.wcnt + 5'h1;
            if (s_reg.wcnt + 5'h1 == s_reg.need) begin
              s_next.cv = 1'b1;
              s_next.st = lnk_pkg::C_HDR;
            end
          end else begin
            s_next.err = 1'b1;
            s_next.wcnt = 5'h0;
            s_next.credit = 1'b1;
            s_next.st = lnk_pkg::C_HDR;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.st <= lnk_pkg::C_HDR;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// *** core/lnk_port_eng.sv ***
// per-fabric-port engine serving one brick pair
`timescale 1ns/1ps
`default_nettype none
`include "lnk_cfg.svh"
module lnk_port_eng (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic odd,
  input wire lnk_pkg::lnk_cmd_t [1:0] cmd,
  input wire logic [1:0] cmd_v,
  output logic [1:0] cmd_take,
  input wire logic [1:0][255:0] beat,
  input wire logic [1:0] beat_v,
  input wire logic [1:0] beat_last,
  output logic [1:0] beat_take,
  output lnk_pkg::lnk_fcmd_t fcmd,
  input wire logic fab_ack,
  input wire lnk_pkg::lnk_fdat_t fdin,
  output lnk_pkg::lnk_fdat_t fdout,
  input wire logic [1:0] tx_rdy,
  output lnk_pkg::lnk_tx_t [1:0] tx
);
  typedef struct packed {
    lnk_pkg::lnk_est_t st;
    logic sel;
    logic rr;
    lnk_pkg::lnk_cmd_t cmd;
    logic [1:0] nl;
    logic [1:0] cnt;
    logic gap;
    logic [1:0] acks;
    logic [3:0] beats;
    logic [3:0] bi;
    logic [4:0] txi;
    logic [15:0][255:0] rbuf;
    logic [1:0] take;
    lnk_pkg::lnk_fcmd_t fcmd;
    lnk_pkg::lnk_fdat_t fdout;
    lnk_pkg::lnk_tx_t [1:0] tx;
  } lnk_eng_s_t;
  lnk_eng_s_t s_reg, s_next;
  logic [8:0] span;
  logic pick;
  logic [4:0] txn;
  logic [127:0] fd;

  assign cmd_take = s_reg.take;
  assign fcmd = s_reg.fcmd;
  assign fdout = s_reg.fdout;
  assign tx = s_reg.tx;
  assign pick = cmd_v[s_reg.rr] ? s_reg.rr : !s_reg.rr;
  assign span = {2'b00, cmd[pick].addr[6:0]} + {1'b0, cmd[pick].sz};
  assign txn = (s_reg.cmd.op == `LNK_OP_RD) ? {s_reg.nl + 2'h1, 3'h0} : 5'h0;

  always_comb begin
    s_next = s_reg;
    s_next.take = 2'b00;
    s_next.fcmd.v = 1'b0;
    s_next.fdout.v = 1'b0;
    beat_take = 2'b00;
    fd = '0;
    for (int i = 0; i < 2; i++) begin
      if (s_reg.tx[i].v && tx_rdy[i]) begin
        s_next.tx[i].v = 1'b0;
      end
    end
    if (s_reg.st != lnk_pkg::E_IDLE) begin
      if (fab_ack) begin
        s_next.acks = s_reg.acks + 2'h1;
      end
      // beats may come back for any octword in any order
      if (fdin.v) begin
        s_next.rbuf[{fdin.line, fdin.oct}] = fdin.d;
        s_next.beats = s_reg.beats + 4'h1;
      end
    end
    unique case (s_reg.st)
      lnk_pkg::E_IDLE: begin
        // one command at a time per brick keeps each brick in order
        if (|cmd_v) begin
          s_next.sel = pick;
          s_next.cmd = cmd[pick];
          s_next.take[pick] = 1'b1;
          s_next.nl = (cmd[pick].op == `LNK_OP_FLS) ? 2'h0 : span[8:7];
          s_next.cnt = 2'h0;
          s_next.gap = 1'b0;
          s_next.acks = 2'h0;
          s_next.beats = 4'h0;
          s_next.bi = 4'h0;
          s_next.txi = 5'h0;
          s_next.st = lnk_pkg::E_ISSUE;
        end
      end
      lnk_pkg::E_ISSUE: begin
        s_next.gap = !s_reg.gap;
        if (!s_reg.gap) begin
          s_next.fcmd.v = 1'b1;
          s_next.fcmd.op = s_reg.cmd.op;
          s_next.fcmd.line = s_reg.cnt;
          s_next.fcmd.addr = {s_reg.cmd.addr[63:`LNK_LINE_SH] + {55'h0, s_reg.cnt}, 7'h00};
          s_next.cnt = s_reg.cnt + 2'h1;
          if (s_reg.cnt == s_reg.nl) begin
            s_next.st = (s_reg.cmd.op == `LNK_OP_WR) ? lnk_pkg::E_WDATA : lnk_pkg::E_WAIT;
          end
        end
      end
      lnk_pkg::E_WDATA: begin
        // one 32-byte beat per cycle while the buffer has data
        if (beat_v[s_reg.sel]) begin
          beat_take[s_reg.sel] = 1'b1;
          s_next.fdout = {1'b1, s_reg.bi[3:2], s_reg.bi[1:0], beat[s_reg.sel]};
          s_next.bi = s_reg.bi + 4'h1;
          if (beat_last[s_reg.sel]) begin
            s_next.st = lnk_pkg::E_WAIT;
          end
        end
      end
      lnk_pkg::E_WAIT: begin
        if (s_reg.acks > s_reg.nl &&
            (s_reg.cmd.op != `LNK_OP_RD || s_reg.beats == {s_reg.nl + 2'h1, 2'b00})) begin
          s_next.st = lnk_pkg::E_RESP;
        end
      end
      lnk_pkg::E_RESP: begin
        if (!s_reg.tx[s_reg.sel].v || tx_rdy[s_reg.sel]) begin
          if (s_reg.txi == 5'h0) begin
            fd = {`LNK_OP_RSP | s_reg.cmd.op, s_reg.cmd.sz, s_reg.cmd.tag, s_reg.cmd.addr};
          end else begin
            fd = s_reg.rbuf[4'((s_reg.txi - 5'h1) >> 1)][((s_reg.txi[0] ? 1 : 0) ^ 1) * 128 +: 128];
          end
          s_next.tx[s_reg.sel] = {1'b1, fd, lnk_pkg::lnk_par(fd, odd)};
          s_next.txi = s_reg.txi + 5'h1;
          if (s_reg.txi == txn) begin
            s_next.rr = !s_reg.sel;
            s_next.st = lnk_pkg::E_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.st <= lnk_pkg::E_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// *** core/lnk_bridge.sv ***
// link transaction bridge top: bricks, fabric ports, snoop, translation
`timescale 1ns/1ps
`default_nettype none
`include "lnk_cfg.svh"
// Summary of operation
// - each brick ordered on its own stream
// - six bricks, pairs fixed to three ports
// - fabric command at most every two cycles
// - outbound fabric data 32 bytes, back-to-back
// - inbound fabric data any octword any cycle
// - receive flits 16 bytes, four parity bits
// - transmit flits 16 bytes, four parity bits
// - transfers from 1 to 256 bytes
// - coherent operations on 128-byte lines
// - snoop accelerator memory and register accesses
// - register accesses out on left/right ports
// - link command becomes fabric sequence, then response
// - reads, writes, probes, flushes, both directions
// - validate, buffer, format; credits track space
// - translation request via context to mmu
// - invalidates snooped become shoot-down requests
// - context table sizes 15/256/256/256
// - relocation cache, walk on miss, error interrupt
// - validation table holds 16 entries
// - only fully checked commands are buffered
// - accelerator response data held for snoops
module lnk_bridge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic odd_parity,
  input wire logic [5:0] err_clr,
  input wire lnk_pkg::lnk_rx_t [5:0] rx,
  input wire logic [5:0] tx_rdy,
  output lnk_pkg::lnk_tx_t [5:0] tx,
  output logic [5:0] credit,
  output logic [5:0] err_log,
  output lnk_pkg::lnk_fcmd_t [2:0] fcmd,
  input wire logic [2:0] fab_ack,
  input wire lnk_pkg::lnk_fdat_t [2:0] fdin,
  output lnk_pkg::lnk_fdat_t [2:0] fdout,
  input wire lnk_pkg::lnk_snp_t snp,
  output lnk_pkg::lnk_snp_t acc_cmd,
  input wire lnk_pkg::lnk_line_t acc_rsp,
  output lnk_pkg::lnk_line_t snp_data,
  output lnk_pkg::lnk_pri_t pri_left,
  output lnk_pkg::lnk_pri_t pri_right,
  output lnk_pkg::lnk_xrsp_t shoot,
  input wire lnk_pkg::lnk_xreq_t xreq,
  output logic xlate_busy,
  output lnk_pkg::lnk_xrsp_t mmu_req,
  input wire lnk_pkg::lnk_xrsp_t mmu_rsp,
  output lnk_pkg::lnk_xrsp_t xrsp,
  input wire lnk_pkg::lnk_xreq_t reloc_req,
  output lnk_pkg::lnk_xrsp_t reloc_rsp,
  output lnk_pkg::lnk_xrsp_t walk_req,
  input wire lnk_pkg::lnk_xrsp_t walk_rsp,
  output logic reloc_irq
);
  typedef struct packed {
    logic [5:0] err;
    lnk_pkg::lnk_snp_t acc;
    lnk_pkg::lnk_line_t poc;
    lnk_pkg::lnk_line_t sd;
    lnk_pkg::lnk_pri_t pl;
    lnk_pkg::lnk_pri_t pr;
    lnk_pkg::lnk_xrsp_t shoot;
    logic [255:0][8:0] ctx;
    logic xbusy;
    lnk_pkg::lnk_xrsp_t mreq;
    lnk_pkg::lnk_xrsp_t xrsp;
    lnk_pkg::lnk_tvt_t [15:0] tvt;
    logic [3:0] rr;
    logic rbusy;
    logic [63:0] raddr;
    lnk_pkg::lnk_xrsp_t rrsp;
    lnk_pkg::lnk_xrsp_t walk;
    logic irq;
  } lnk_top_s_t;
  lnk_top_s_t s_reg, s_next;
  lnk_pkg::lnk_cmd_t [5:0] cmd;
  logic [5:0] cmd_v;
  logic [5:0] cmd_take;
  logic [5:0][255:0] beat;
  logic [5:0] beat_v;
  logic [5:0] beat_last;
  logic [5:0] beat_take;
  logic [5:0] chk_err;

  // ----------------------------------------
  // bricks and fabric ports
  // ----------------------------------------
  for (genvar b = 0; b < `LNK_NB; b++) begin : g_brick
    lnk_flow_control_digit_check u_chk (
      .clk(clk),
      .rst_n(rst_n),
      .odd(odd_parity),
      .rx(rx[b]),
      .cmd(cmd[b]),
      .cmd_v(cmd_v[b]),
      .cmd_take(cmd_take[b]),
      .beat(beat[b]),
      .beat_v(beat_v[b]),
      .beat_last(beat_last[b]),
      .beat_take(beat_take[b]),
      .credit(credit[b]),
      .err(chk_err[b])
    );
  end

  // bricks 2p and 2p+1 feed port p
  for (genvar p = 0; p < `LNK_NP; p++) begin : g_port
    lnk_port_eng u_eng (
      .clk(clk),
      .rst_n(rst_n),
      .odd(odd_parity),
      .cmd(cmd[2*p +: 2]),
      .cmd_v(cmd_v[2*p +: 2]),
      .cmd_take(cmd_take[2*p +: 2]),
      .beat(beat[2*p +: 2]),
      .beat_v(beat_v[2*p +: 2]),
      .beat_last(beat_last[2*p +: 2]),
      .beat_take(beat_take[2*p +: 2]),
      .fcmd(fcmd[p]),
      .fab_ack(fab_ack[p]),
      .fdin(fdin[p]),
      .fdout(fdout[p]),
      .tx_rdy(tx_rdy[2*p +: 2]),
      .tx(tx[2*p +: 2])
    );
  end

  assign err_log = s_reg.err;
  assign acc_cmd = s_reg.acc;
  assign snp_data = s_reg.sd;
  assign pri_left = s_reg.pl;
  assign pri_right = s_reg.pr;
  assign shoot = s_reg.shoot;
  assign xlate_busy = s_reg.xbusy;
  assign mmu_req = s_reg.mreq;
  assign xrsp = s_reg.xrsp;
  assign reloc_rsp = s_reg.rrsp;
  assign walk_req = s_reg.walk;
  assign reloc_irq = s_reg.irq;

  // ----------------------------------------
  // snoop, translation, relocation
  // ----------------------------------------
  always_comb begin
    logic hit;
    logic [3:0] hi;
    hit = 1'b0;
    hi = 4'h0;
    s_next = s_reg;
    s_next.acc.v = 1'b0;
    s_next.sd.v = 1'b0;
    s_next.pl.v = 1'b0;
    s_next.pr.v = 1'b0;
    s_next.shoot.v = 1'b0;
    s_next.mreq.v = 1'b0;
    s_next.xrsp.v = 1'b0;
    s_next.rrsp.v = 1'b0;
    s_next.walk.v = 1'b0;
    s_next.irq = 1'b0;
    // set wins over software clear
    s_next.err = (s_reg.err & ~err_clr) | chk_err;
    // accelerator response held as a small cache line
    if (acc_rsp.v) begin
      s_next.poc = acc_rsp;
    end
    if (snp.v) begin
      if (snp.op == `LNK_SN_INV) begin
        s_next.shoot = {1'b1, 1'b1, 8'h00, snp.addr};
      end else if (snp.addr[63:48] == `LNK_ACC_BASE) begin
        if (snp.op == `LNK_SN_LD && s_reg.poc.v &&
            s_reg.poc.addr[63:`LNK_LINE_SH] == snp.addr[63:`LNK_LINE_SH]) begin
          s_next.sd = s_reg.poc;
        end else begin
          s_next.acc = snp;
          if (snp.op == `LNK_SN_ST) begin
            s_next.poc.v = 1'b0;
          end
        end
      end else if (snp.addr[63:48] == `LNK_REG_BASE) begin
        if (snp.addr[`LNK_REG_OWN]) begin
          if (snp.op == `LNK_SN_ST && snp.addr[`LNK_REG_TVT]) begin
            s_next.tvt[snp.addr[6:3]] = {1'b1, snp.d[39:20], snp.d[19:0]};
          end else if (snp.op == `LNK_SN_ST) begin
            s_next.ctx[snp.addr[10:3]] = snp.d[8:0];
          end
        end else if (snp.addr[`LNK_REG_RIGHT]) begin
          s_next.pr = {1'b1, snp.op == `LNK_SN_ST, snp.addr[31:0], snp.d};
        end else begin
          s_next.pl = {1'b1, snp.op == `LNK_SN_ST, snp.addr[31:0], snp.d};
        end
      end
    end
    // translation: context lookup, then mmu, then response
    if (xreq.v && !s_reg.xbusy) begin
      if (xreq.bdf <= `LNK_BDF_MAX && s_reg.ctx[xreq.pasid][8]) begin
        s_next.mreq = {1'b1, 1'b1, s_reg.ctx[xreq.pasid][7:0], xreq.addr};
        s_next.xbusy = 1'b1;
      end else begin
        s_next.xrsp = {1'b1, 1'b0, 8'h00, xreq.addr};
      end
    end
    if (mmu_rsp.v && s_reg.xbusy) begin
      s_next.xrsp = mmu_rsp;
      s_next.xbusy = 1'b0;
    end
    for (int i = 0; i < 16; i++) begin
      if (s_reg.tvt[i].v && s_reg.tvt[i].tag == reloc_req.addr[31:`LNK_PG_SH]) begin
        hit = 1'b1;
        hi = 4'(i);
      end
    end
    if (reloc_req.v && !s_reg.rbusy) begin
      if (reloc_req.bdf > `LNK_BDF_MAX) begin
        s_next.irq = 1'b1;
      end else if (hit) begin
        s_next.rrsp = {1'b1, 1'b1, 8'h00, 32'h0, s_reg.tvt[hi].base, reloc_req.addr[11:0]};
      end else begin
        s_next.walk = {1'b1, 1'b1, 8'h00, reloc_req.addr};
        s_next.raddr = reloc_req.addr;
        s_next.rbusy = 1'b1;
      end
    end
    if (walk_rsp.v && s_reg.rbusy) begin
      s_next.rbusy = 1'b0;
      if (walk_rsp.ok) begin
        s_next.tvt[s_reg.rr] = {1'b1, s_reg.raddr[31:`LNK_PG_SH], walk_rsp.addr[31:12]};
        s_next.rr = s_reg.rr + 4'h1;
        s_next.rrsp = {1'b1, 1'b1, 8'h00, 32'h0, walk_rsp.addr[31:12], s_reg.raddr[11:0]};
      end else begin
        s_next.irq = 1'b1;
        s_next.rrsp = {1'b1, 1'b0, 8'h00, s_reg.raddr};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// *** test/lnk_bridge_assertions.sv ***
// port checker of the link transaction bridge
`timescale 1ns/1ps
`default_nettype none
`include "lnk_cfg.svh"
module lnk_bridge_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic odd_parity,
  input wire lnk_pkg::lnk_rx_t [5:0] rx,
  input wire logic [5:0] tx_rdy,
  input wire lnk_pkg::lnk_tx_t [5:0] tx,
  input wire logic [5:0] err_log,
  input wire lnk_pkg::lnk_fcmd_t [2:0] fcmd,
  input wire lnk_pkg::lnk_snp_t snp,
  input wire lnk_pkg::lnk_snp_t acc_cmd,
  input wire lnk_pkg::lnk_line_t snp_data,
  input wire lnk_pkg::lnk_pri_t pri_left,
  input wire lnk_pkg::lnk_pri_t pri_right,
  input wire lnk_pkg::lnk_xrsp_t shoot,
  input wire lnk_pkg::lnk_xreq_t xreq,
  input wire logic xlate_busy,
  input wire lnk_pkg::lnk_xrsp_t xrsp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] rx_par;
  logic [3:0] tx_par;
  logic reg_hit;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rx_par[i] = ^rx[0].f.d[32*i +: 32] ^ odd_parity;
      tx_par[i] = ^tx[0].f.d[32*i +: 32] ^ odd_parity;
    end
  end
  assign reg_hit = snp.v && snp.op != `LNK_SN_INV && snp.addr[63:48] == `LNK_REG_BASE
      && !snp.addr[`LNK_REG_OWN];
  a_fcmd_gap: assert property (fcmd[0].v |=> !fcmd[0].v)
    else $error("fabric commands on adjacent cycles");
  a_fcmd_align: assert property (fcmd[0].v |-> fcmd[0].addr[6:0] == 7'h0)
    else $error("fabric command not line aligned");
  a_tx_hold: assert property (tx[0].v && !tx_rdy[0] |=> tx[0].v && $stable(tx[0].f))
    else $error("transmit flow_control_digit not held while stalled");
  a_tx_parity: assert property (tx[0].v |-> tx[0].f.p == tx_par)
    else $error("transmit flow_control_digit parity wrong");
  a_rx_parity: assert property (rx[0].v && rx[0].f.p != rx_par |-> ##[1:2] err_log[0])
    else $error("bad parity flow_control_digit not logged");
  a_rx_crc: assert property (rx[0].v && !rx[0].crc_ok |-> ##[1:2] err_log[0])
    else $error("bad crc flow_control_digit not logged");
  a_pri_right: assert property (reg_hit && snp.addr[20] |=> pri_right.v && !pri_left.v)
    else $error("right register access misrouted");
  a_pri_left: assert property (reg_hit && !snp.addr[20] |=> pri_left.v && !pri_right.v)
    else $error("left register access misrouted");
  a_acc_fwd: assert property (snp.v && snp.op != `LNK_SN_INV &&
      snp.addr[63:48] == `LNK_ACC_BASE |=> acc_cmd.v || snp_data.v)
    else $error("accelerator access not forwarded");
  a_shoot_down: assert property (snp.v && snp.op == `LNK_SN_INV |=> shoot.v)
    else $error("invalidate gave no shoot-down");
  a_bad_bdf: assert property (xreq.v && !xlate_busy && xreq.bdf == 4'hf
      |=> xrsp.v && !xrsp.ok)
    else $error("out of range function not refused");
endmodule
bind lnk_bridge lnk_bridge_chk chk (.clk, .rst_n, .odd_parity, .rx, .tx_rdy, .tx, .err_log,
  .fcmd, .snp, .acc_cmd, .snp_data, .pri_left, .pri_right, .shoot, .xreq, .xlate_busy, .xrsp);
`default_nettype wire

// *** test/lnk_dl_model.sv ***
// datalink side model: accepts transmit flits, checks their parity
`timescale 1ns/1ps
`default_nettype none
module lnk_dl_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic odd_parity,
  input wire lnk_pkg::lnk_tx_t [5:0] tx,
  output logic [5:0] tx_rdy,
  output int perr
);
  logic ph;
  // slow mode accepts on every other cycle only
  assign tx_rdy = slow ? {6{ph}} : 6'h3f;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 1'b0;
      perr <= 0;
    end else begin
      ph <= ~ph;
      for (int b = 0; b < 6; b++) begin
        for (int i = 0; i < 4; i++) begin
          if (tx[b].v && tx_rdy[b] && (^tx[b].f.d[32*i +: 32] ^ odd_parity) !== tx[b].f.p[i]) begin
            perr <= perr + 1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** test/test_lnk_bridge.sv ***
// self-checking bench of the link transaction bridge
`timescale 1ns/1ps
`default_nettype none
`include "lnk_cfg.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module test_lnk_bridge;
  logic clk = 0, rst_n = 0, odd_parity = 0, slow = 0, xlate_busy, reloc_irq;
  logic [5:0] err_clr = '0, tx_rdy, credit, err_log;
  logic [2:0] fab_ack = '0;
  lnk_pkg::lnk_rx_t [5:0] rx = '0;
  lnk_pkg::lnk_tx_t [5:0] tx;
  lnk_pkg::lnk_fcmd_t [2:0] fcmd;
  lnk_pkg::lnk_fdat_t [2:0] fdin = '0, fdout;
  lnk_pkg::lnk_snp_t snp = '0, acc_cmd;
  lnk_pkg::lnk_line_t acc_rsp = '0, snp_data;
  lnk_pkg::lnk_pri_t pri_left, pri_right;
  lnk_pkg::lnk_xreq_t xreq = '0, reloc_req = '0;
  lnk_pkg::lnk_xrsp_t shoot, mmu_req, xrsp, reloc_rsp, walk_req, mmu_rsp = '0, walk_rsp = '0;
  int error_cnt = 0, num_checks = 0, perr, fcnt [3] = '{0, 0, 0}, tcnt [6] = '{default: 0};
  logic [63:0] faddr [3];
  logic [7:0] fop [3];
  logic [255:0] fwd [3];
  logic [127:0] tfl [6][20];
  logic [2:0] fq [3][$];
  logic [1:0] foct [3] = '{2'h3, 2'h3, 2'h3};
  always #12.5 clk = ~clk;
  lnk_bridge uut (.clk, .rst_n, .odd_parity, .err_clr, .rx, .tx_rdy, .tx, .credit, .err_log,
    .fcmd, .fab_ack, .fdin, .fdout, .snp, .acc_cmd, .acc_rsp, .snp_data, .pri_left, .pri_right,
    .shoot, .xreq, .xlate_busy, .mmu_req, .mmu_rsp, .xrsp, .reloc_req, .reloc_rsp, .walk_req,
    .walk_rsp, .reloc_irq);
  lnk_dl_model dl (.clk, .rst_n, .slow, .odd_parity, .tx, .tx_rdy, .perr);
  function automatic logic [255:0] bt(input logic [1:0] l, input logic [1:0] o);
    return {8{24'h5a5a00, 2'h0, l, 2'h0, o}};
  endfunction
  function automatic logic [3:0] par(input logic [127:0] d);
    for (int i = 0; i < 4; i++) par[i] = ^d[32*i +: 32] ^ odd_parity;
  endfunction
  // ------------
  // fabric side: acks and read beats, octwords in reverse order
  // ------------
  always @(posedge clk) begin
    for (int p = 0; p < 3; p++) begin
      fab_ack[p] <= 1'b0;
      fdin[p] <= '0;
      if (fcmd[p].v) begin
        fq[p].push_back({fcmd[p].op == `LNK_OP_RD, fcmd[p].line});
        fcnt[p] <= fcnt[p] + 1;
        fop[p] <= fcmd[p].op;
        faddr[p] <= fcmd[p].addr;
      end
      if (fdout[p].v) fwd[p] <= fdout[p].d;
      if (fq[p].size() > 0 && !fq[p][0][2]) begin
        fab_ack[p] <= 1'b1;
        void'(fq[p].pop_front());
      end else if (fq[p].size() > 0) begin
        fdin[p] <= '{v: 1'b1, line: fq[p][0][1:0], oct: foct[p], d: bt(fq[p][0][1:0], foct[p])};
        foct[p] <= foct[p] - 2'h1;
        if (foct[p] == 2'h0) begin
          fab_ack[p] <= 1'b1;
          void'(fq[p].pop_front());
        end
      end
    end
    for (int b = 0; b < 6; b++) begin
      if (tx[b].v && tx_rdy[b]) begin
        tfl[b][tcnt[b] % 20] <= tx[b].f.d;
        tcnt[b] <= tcnt[b] + 1;
      end
    end
  end
  // ------------
  // tasks
  // ------------
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 300) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  task automatic send(input int b, input logic [127:0] d, input logic bad, input logic crc);
    @(posedge clk);
    rx[b] <= '{v: 1'b1, crc_ok: crc, f: '{d: d, p: par(d) ^ {3'h0, bad}}};
    @(posedge clk);
    rx[b] <= '0;
  endtask
  task automatic run_cmd(input int b, input logic [7:0] op, input logic [7:0] sz,
      input logic [63:0] ad, input int lines, input int flits);
    int p, f0, t0, n;
    logic got;
    p = b / 2;
    f0 = fcnt[p];
    t0 = tcnt[b];
    got = 0;
    send(b, {op, sz, 48'h00c0de, ad}, 1'b0, 1'b1);
    for (int k = 0; op == `LNK_OP_WR && k <= sz[7:4]; k++) send(b, {16{8'(k + 'h31)}}, 1'b0, 1'b1);
    for (n = 0; n < 300 && !(got && (flits < 0 || tcnt[b] - t0 >= flits)); n++) begin
      @(negedge clk);
      if (credit[b] === 1'b1) got = 1;
    end
    tmo(n);
    repeat (8) @(negedge clk);
    `CHK(fcnt[p] - f0, lines)
    `CHK(fop[p], op)
    `CHK(faddr[p], {ad[63:7], 7'h0} + 64'((lines - 1) * 128))
    if (flits >= 0) `CHK(tcnt[b] - t0, flits)
    if (op == `LNK_OP_RD) `CHK(tfl[b][(t0 + 1) % 20], bt(2'h0, 2'h0) >> 128)
    if (op == `LNK_OP_WR) `CHK(fwd[p], {{16{8'h32}}, {16{8'h31}}})
  endtask
  task automatic t_err();
    int n;
    for (int k = 0; k < 3; k++) begin
      send(0, {k == 2 ? 8'h07 : `LNK_OP_RD, 120'h0}, k == 0, k != 1);
      @(negedge clk);
      for (n = 0; n < 300 && err_log[0] !== 1'b1; n++) @(negedge clk);
      tmo(n);
      @(posedge clk);
      err_clr[0] <= 1'b1;
      @(posedge clk);
      err_clr[0] <= 1'b0;
      @(negedge clk);
      `CHK(err_log[0], 1'b0)
    end
    @(posedge clk);
    odd_parity <= 1'b1;
  endtask
  task automatic t_snoop();
    logic [1:0] op [5] = '{`LNK_SN_LD, `LNK_SN_ST, `LNK_SN_LD, `LNK_SN_INV, `LNK_SN_LD};
    logic [63:0] ad [5] = '{64'h0040_0000_0000_1000, 64'h0060_0000_0010_0008,
      64'h0060_0000_0000_0010, 64'h2000, 64'h0040_0000_0000_1040};
    logic [4:0] ex [5] = '{5'h10, 5'h4, 5'h8, 5'h2, 5'h1};
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      snp <= '{v: 1'b1, op: op[k], addr: ad[k], d: 64'h0};
      acc_rsp <= '{v: k == 3, addr: ad[0], d: '1};
      @(posedge clk);
      snp <= '0;
      acc_rsp.v <= 1'b0;
      @(negedge clk);
      `CHK({acc_cmd.v, pri_left.v, pri_right.v, shoot.v, snp_data.v}, ex[k])
      if (k == 1) `CHK(pri_right.we, 1'b1)
    end
  endtask
  task automatic t_xlate_reloc();
    int n;
    @(posedge clk);
    xreq <= '{v: 1'b1, bdf: 4'hf, pasid: 8'h3, addr: 64'h6000};
    reloc_req <= '{v: 1'b1, bdf: 4'h1, pasid: 8'h0, addr: 64'h7000};
    @(posedge clk);
    xreq <= '0;
    reloc_req <= '0;
    @(negedge clk);
    `CHK({xrsp.v, xrsp.ok}, 2'b10)
    for (n = 0; n < 300 && walk_req.v !== 1'b1; n++) @(negedge clk);
    tmo(n);
    @(posedge clk);
    walk_rsp <= '{v: 1'b1, ok: 1'b0, ctx: 8'h0, addr: 64'h0};
    @(posedge clk);
    walk_rsp <= '0;
    @(negedge clk);
    for (n = 0; n < 300 && reloc_irq !== 1'b1; n++) @(negedge clk);
    tmo(n);
    `CHK({reloc_irq, reloc_rsp.v, reloc_rsp.ok}, 3'h6)
  endtask
  // ------------
  // main sequence
  // ------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    slow <= 1'b1;
    run_cmd(1, `LNK_OP_RD, 8'h7f, 64'h1000, 1, 9);
    run_cmd(4, `LNK_OP_RD, 8'hff, 64'h3000, 2, 17);
    run_cmd(2, `LNK_OP_WR, 8'h1f, 64'h2040, 1, 1);
    t_err();
    run_cmd(0, `LNK_OP_FLS, 8'h00, 64'h4000, 1, 1);
    run_cmd(3, `LNK_OP_PRB, 8'h00, 64'h5000, 1, 1);
    t_snoop();
    t_xlate_reloc();
    `CHK(perr, 0)
    end_of_test();
  end
endmodule
`default_nettype wire
